// File: hdl/spcc_defs.svh
// Constants for the serial port clock control block
`ifndef SPCC_DEFS_SVH
`define SPCC_DEFS_SVH

`define SPCC_MCLK_PERIOD_NS  20
`define SPCC_SCLK_HALF_NS    80
`define SPCC_SCLK_HALF_CYC   ((`SPCC_SCLK_HALF_NS + `SPCC_MCLK_PERIOD_NS - 1) / `SPCC_MCLK_PERIOD_NS)
`define SPCC_WORD_BITS       24
`define SPCC_FIFO_DEPTH      32
`define SPCC_SCLK_IDLE       1'b1
`define SPCC_PIN_RST         7'h26

`endif

// File: hdl/spcc_fifo.sv
// Synchronous FIFO for received words, depth a power of two
`timescale 1ns/1ps

module spcc_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 32
) (
    input  wire logic mclk,
    input  wire logic rst,
    spcc_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr_q;
    logic [AW:0]      rptr_q;
    wire              empty_w = (wptr_q == rptr_q);
    wire              full_w  = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
    wire              push_w  = port.wvalid && !full_w;
    wire              pop_w   = port.rready && !empty_w;

    // Status and head word
    assign port.wready = !full_w;
    assign port.rvalid = !empty_w;
    assign port.rdata  = mem[rptr_q[AW-1:0]];

    // Storage has no reset; only the pointers define the contents
    always_ff @(posedge mclk) begin
        if (push_w) begin
            mem[wptr_q[AW-1:0]] <= port.wdata;
        end
    end

    // Pointers with a wrap bit so full and empty are told apart
    always_ff @(posedge mclk) begin
        if (rst) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            if (push_w) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop_w) begin
                rptr_q <= rptr_q + 1'b1;
            end
        end
    end
endmodule

// File: hdl/spcc_fifo_if.sv
// Valid/ready carrier between the frame logic and the receive FIFO
`timescale 1ns/1ps

interface spcc_fifo_if #(
    parameter int WIDTH = 25
);
    logic [WIDTH-1:0] wdata;
    logic             wvalid;
    logic             wready;
    logic [WIDTH-1:0] rdata;
    logic             rvalid;
    logic             rready;

    modport fill  (output wdata, output wvalid, input wready);
    modport drain (input rdata, input rvalid, output rready);
    modport fifo  (input wdata, input wvalid, input rready, output wready, output rdata, output rvalid);
endinterface

// File: hdl/spcc_pkg.sv
// Types shared by the serial port clock control block
`include "spcc_defs.svh"

package spcc_pkg;

    typedef enum logic [1:0] {
        spcc_idle,
        spcc_read,
        spcc_write,
        spcc_done
    } spcc_state_e;

    typedef logic [`SPCC_WORD_BITS-1:0] spcc_word_t;

endpackage

// File: hdl/spcc_top.sv
// Serial port with self or external clocking, frame control and receive FIFO
//
// Summary of operation
// - Mode high: device drives serial clock
// - Self clock starts only after frame sync low
// - Release clock on frame end or word done
// - Mode low: serial clock is input only
// - External bursts keep bit position between groups
// - Register select: low control, high data
// - Filter sync input resets filter nodes
`timescale 1ns/1ps
`include "spcc_defs.svh"

module spcc_top #(
    parameter int WORD_BITS  = `SPCC_WORD_BITS,
    parameter int FIFO_DEPTH = `SPCC_FIFO_DEPTH,
    parameter int HALF_CYC   = `SPCC_SCLK_HALF_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 mode,
    input  wire logic                 receive_frame_sync_n,
    input  wire logic                 transmit_frame_sync_n,
    input  wire logic                 register_select,
    input  wire logic                 filter_sync,
    input  wire logic                 sclk_i,
    output logic                      sclk_o,
    output logic                      sclk_oe,
    input  wire logic                 sdata_i,
    output logic                      sdata_o,
    output logic                      sdata_oe,
    input  wire logic [WORD_BITS-1:0] ctrl_rd_word,
    input  wire logic [WORD_BITS-1:0] data_rd_word,
    output logic [WORD_BITS:0]        rx_data,
    output logic                      rx_valid,
    input  wire logic                 rx_ready,
    output logic                      rx_overflow,
    output logic                      filter_reset
);
    import spcc_pkg::*;

    localparam int CW = $clog2(WORD_BITS + 1);
    localparam int DW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] LAST_BIT = CW'(WORD_BITS - 1);
    localparam logic [DW-1:0] LAST_DIV = DW'(HALF_CYC - 1);

    spcc_fifo_if #(.WIDTH(WORD_BITS + 1)) rx_if ();

    spcc_fifo #(
        .WIDTH (WORD_BITS + 1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk (mclk),
        .rst  (rst),
        .port (rx_if.fifo)
    );

    // Pin synchronisers: three stages, a change is taken once stages two and three agree
    logic [6:0] pin_s1_q;
    logic [6:0] pin_s2_q;
    logic [6:0] pin_s3_q;
    logic [6:0] pin_q;
    wire  [6:0] pin_raw = {sdata_i, sclk_i, filter_sync, register_select,
                           transmit_frame_sync_n, receive_frame_sync_n, mode};
    wire  [6:0] pin_d   = (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_s1_q <= `SPCC_PIN_RST;
            pin_s2_q <= `SPCC_PIN_RST;
            pin_s3_q <= `SPCC_PIN_RST;
            pin_q    <= `SPCC_PIN_RST;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q    <= pin_d;
        end
    end

    // Named views of the filtered pins
    wire self_w   = pin_q[0];
    wire rfs_n_w  = pin_q[1];
    wire tfs_n_w  = pin_q[2];
    wire regsel_w = pin_q[3];
    wire fsync_w  = pin_q[4];
    wire sclk_w   = pin_q[5];
    wire din_w    = pin_q[6];

    spcc_state_e          state_q;
    spcc_state_e          state_d;
    logic [CW-1:0]        bit_cnt_q;
    logic [CW-1:0]        bit_cnt_d;
    logic [WORD_BITS-1:0] shift_q;
    logic [WORD_BITS-1:0] shift_d;
    logic                 regsel_q;
    logic                 regsel_d;
    logic [DW-1:0]        div_cnt_q;
    logic                 sclk_prev_q;
    logic                 push_q;
    logic [WORD_BITS:0]   push_data_q;

    // Clock generator runs only inside an open frame in self-clocking mode
    wire in_frame_w = (state_q == spcc_read) || (state_q == spcc_write);
    wire gen_run_w  = self_w && in_frame_w;
    wire tick_w     = gen_run_w && (div_cnt_q == LAST_DIV);
    wire gen_rise_w = tick_w && !sclk_o;
    wire gen_fall_w = tick_w && sclk_o;

    // External edges, found on the filtered pin level
    wire ext_rise_w = !self_w && sclk_w && !sclk_prev_q;
    wire ext_fall_w = !self_w && !sclk_w && sclk_prev_q;
    wire rise_w     = self_w ? gen_rise_w : ext_rise_w;
    wire fall_w     = self_w ? gen_fall_w : ext_fall_w;
    wire last_w     = (bit_cnt_q == LAST_BIT);

    // Word offered on a read frame follows the register select level
    wire [WORD_BITS-1:0] rd_word_w = regsel_w ? data_rd_word : ctrl_rd_word;
    wire [WORD_BITS-1:0] in_word_w = {shift_q[WORD_BITS-2:0], din_w};

    // Frame sequencer; the bit counter only moves on clock edges, so gaps between bursts keep it
    always_comb begin
        state_d   = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d   = shift_q;
        regsel_d  = regsel_q;
        case (state_q)
            spcc_idle: begin
                bit_cnt_d = '0;
                if (!rfs_n_w) begin
                    state_d  = spcc_read;
                    shift_d  = rd_word_w;
                    regsel_d = regsel_w;
                end else if (!tfs_n_w && rx_if.wready) begin
                    // Write frame waits for room so a word is not lost at the end
                    state_d  = spcc_write;
                    regsel_d = regsel_w;
                end
            end
            spcc_read: begin
                if (rfs_n_w) begin
                    state_d = spcc_idle;
                end else if (rise_w) begin
                    bit_cnt_d = bit_cnt_q + 1'b1;
                    if (last_w) begin
                        state_d = spcc_done;
                    end
                end else if (fall_w && bit_cnt_q != '0) begin
                    // MSB stands from frame start; later bits move on falling edges
                    shift_d = {shift_q[WORD_BITS-2:0], 1'b0};
                end
            end
            spcc_write: begin
                if (tfs_n_w) begin
                    state_d = spcc_idle;
                end else if (rise_w) begin
                    shift_d   = in_word_w;
                    bit_cnt_d = bit_cnt_q + 1'b1;
                    if (last_w) begin
                        state_d = spcc_done;
                    end
                end
            end
            spcc_done: begin
                if (rfs_n_w && tfs_n_w) begin
                    state_d = spcc_idle;
                end
            end
            default: begin
                state_d = spcc_idle;
            end
        endcase
    end

    wire push_w     = (state_q == spcc_write) && !tfs_n_w && rise_w && last_w;
    wire run_next_w = (state_d == spcc_read) || (state_d == spcc_write);

    // Sequencer registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q   <= spcc_idle;
            bit_cnt_q <= '0;
            shift_q   <= '0;
            regsel_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q   <= shift_d;
            regsel_q  <= regsel_d;
        end
    end

    // Divider and generated clock; the clock parks high so the last edge seen is a rising one
    always_ff @(posedge mclk) begin
        if (rst || !gen_run_w) begin
            div_cnt_q <= '0;
            sclk_o    <= `SPCC_SCLK_IDLE;
        end else if (tick_w) begin
            div_cnt_q <= '0;
            sclk_o    <= !sclk_o;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    // Pin drivers are registered from the next state so they open and close with the frame
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_oe     <= 1'b0;
            sdata_oe    <= 1'b0;
            sdata_o     <= 1'b0;
            sclk_prev_q <= `SPCC_SCLK_IDLE;
        end else begin
            // Drivers stay on one cycle past the last rising edge, or the host loses bit zero
            sclk_oe     <= self_w && (run_next_w || in_frame_w);
            sdata_oe    <= (state_d == spcc_read) || (state_q == spcc_read);
            sdata_o     <= shift_d[WORD_BITS-1];
            sclk_prev_q <= sclk_w;
        end
    end

    // Received word hand-off; a word that finds the FIFO full is dropped and flagged
    always_ff @(posedge mclk) begin
        if (rst) begin
            push_q      <= 1'b0;
            push_data_q <= '0;
            rx_overflow <= 1'b0;
        end else begin
            push_q      <= push_w;
            push_data_q <= push_w ? {regsel_q, in_word_w} : push_data_q;
            rx_overflow <= push_q && !rx_if.wready;
        end
    end

    assign rx_if.wvalid = push_q;
    assign rx_if.wdata  = push_data_q;
    assign rx_if.rready = !rx_valid || rx_ready;

    // Output stage keeps the user outputs on flip-flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_valid <= 1'b0;
            rx_data  <= '0;
        end else if (rx_if.rready) begin
            rx_valid <= rx_if.rvalid;
            rx_data  <= rx_if.rdata;
        end
    end

    // Filter reset follows the synchronised input level
    always_ff @(posedge mclk) begin
        if (rst) begin
            filter_reset <= 1'b0;
        end else begin
            filter_reset <= fsync_w;
        end
    end
endmodule

// File: sim/spcc_chk.sv
// Port assertions for the serial clock control block
`timescale 1ns/1ps
module spcc_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mode,
    input wire logic receive_frame_sync_n,
    input wire logic transmit_frame_sync_n,
    input wire logic filter_sync,
    input wire logic sclk_o,
    input wire logic sclk_oe,
    input wire logic sdata_oe,
    input wire logic filter_reset
);
    wire r_n = receive_frame_sync_n;
    wire t_n = transmit_frame_sync_n;
    // Pins cross a synchroniser, so effects trail causes by about five cycles
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_ext_no_drive: assert property (!mode [*7] |-> !sclk_oe)
        else $error("clock driven in external mode");
    a_self_starts: assert property (mode [*8] ##0 $fell(r_n) ##1 !r_n [*4] |-> ##[1:3] sclk_oe)
        else $error("self clock not started");
    a_first_fall: assert property ($rose(sclk_oe) |-> (!r_n || !t_n) ##0 sclk_o [*4] ##1 !sclk_o)
        else $error("bad clock start");
    a_low_phase: assert property ($fell(sclk_o) |-> (!sclk_o [*4] ##1 sclk_o) or ##[0:4] !sclk_oe)
        else $error("low phase not four cycles");
    a_high_phase: assert property ($rose(sclk_o) && sclk_oe |-> sclk_o [*4])
        else $error("high phase short");
    a_sync_release: assert property (($rose(r_n) || $rose(t_n)) && r_n && t_n |-> ##[1:7] !sclk_oe && !sdata_oe)
        else $error("clock not released");
    a_idle_high: assert property (!sclk_oe [*2] |-> sclk_o)
        else $error("idle clock not high");
    a_filter_follow: assert property ($stable(filter_sync) [*7] |-> filter_reset == filter_sync)
        else $error("filter reset wrong");
endmodule
bind spcc_top spcc_chk chk_u (.*);

// File: sim/spcc_host.sv
// Host serial port model: frame syncs, external clock and data pin
`timescale 1ns/1ps
module spcc_host (
    input  wire logic mclk,
    input  wire logic sclk_o,
    input  wire logic sclk_oe,
    input  wire logic sdata_o,
    input  wire logic sdata_oe,
    output logic      sclk_i,
    output logic      sdata_i,
    output logic      receive_frame_sync_n,
    output logic      transmit_frame_sync_n
);
    logic clk_q = 1'b1;
    logic dat_q = 1'b0;
    logic rs_q = 1'b1;
    logic ts_q = 1'b1;
    // Pin levels: the enabled party drives; host clock rests high outside frames
    assign sclk_i = sclk_oe ? sclk_o : clk_q;
    assign sdata_i = sdata_oe ? sdata_o : dat_q;
    assign receive_frame_sync_n = rs_q;
    assign transmit_frame_sync_n = ts_q;
    // Move one frame sync; rd picks the read line
    task automatic sync(input logic rd, input logic lvl);
        @(posedge mclk);
        rs_q <= rd ? lvl : rs_q;
        ts_q <= rd ? ts_q : lvl;
    endtask
    // Host-clocked word, MSB first; long low phase keeps sampling clear of data changes
    task automatic xfer(input logic rd, input logic [23:0] w, input int grp, output logic [23:0] got);
        sync(rd, 1'b0);
        repeat (6) @(posedge mclk);
        for (int i = 23; i >= 0; i--) begin
            clk_q <= 1'b0;
            dat_q <= w[i];
            repeat (8) @(posedge mclk);
            got[i] = sdata_i;
            clk_q <= 1'b1;
            repeat (i % grp == 0 ? 16 : 4) @(posedge mclk);
        end
        sync(rd, 1'b1);
        dat_q <= !w[0];
        repeat (8) @(posedge mclk);
    endtask
    // Device-clocked read; a clock still driven after the word spoils the count
    task automatic self_rd(output logic [23:0] got, output int n);
        logic p;
        p = 1'b1;
        n = 0;
        sync(1'b1, 1'b0);
        for (int k = 0; k < 400 && n < 24; k++) begin
            @(negedge mclk);
            if (sclk_oe && sclk_i && !p) begin
                got = {got[22:0], sdata_i};
                n++;
            end
            p = sclk_i;
        end
        repeat (2) @(negedge mclk);
        n += sclk_oe ? 100 : 0;
        sync(1'b1, 1'b1);
        repeat (10) @(posedge mclk);
    endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the serial clock control block
`timescale 1ns/1ps
module tb_top;
    import spcc_pkg::*;
    localparam spcc_word_t CTRL_W = 24'hA5C3F1;
    localparam spcc_word_t DATA_W = 24'h3C0F96;
    logic mclk, rst, mode, register_select, filter_sync, rx_ready, sclk_i, sdata_i;
    logic receive_frame_sync_n, transmit_frame_sync_n, sclk_o, sclk_oe, sdata_o, sdata_oe;
    logic rx_valid, rx_overflow, filter_reset;
    logic [24:0] rx_data;
    spcc_word_t ctrl_rd_word, data_rd_word;
    int err_total;
    int checks;
    logic ovf_seen;
    // Overflow is a one-cycle pulse, so remember any occurrence
    always @(posedge mclk) begin
        if (rst) begin
            ovf_seen <= 1'b0;
        end else if (rx_overflow === 1'b1) begin
            ovf_seen <= 1'b1;
        end
    end
    assign ctrl_rd_word = CTRL_W;
    assign data_rd_word = DATA_W;
    spcc_top dut_u (.*);
    spcc_host host_u (.*);
    task automatic cmp(input logic [24:0] e, input logic [24:0] g, input string m);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Bounded wait for a received word; a hang ends the run
    task automatic get_rx(output logic [24:0] d);
        int k;
        for (k = 0; k < 600; k++) begin
            @(negedge mclk);
            if (rx_valid === 1'b1) break;
        end
        if (k == 600) begin
            err_total++;
            $display("CHECK FAILED at %0t: no word", $time);
            conclude();
        end
        d = rx_data;
        // Ready stands until the edge that moves the word, then drops again
        @(posedge mclk);
        rx_ready <= 1'b1;
        @(posedge mclk);
        rx_ready <= 1'b0;
    endtask
    task automatic t_self();
        logic [23:0] got;
        int n;
        mode <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            register_select <= s[0];
            repeat (10) @(posedge mclk);
            host_u.self_rd(got, n);
            cmp(25'd24, 25'(n), "bits");
            cmp(25'(s ? DATA_W : CTRL_W), 25'(got), "word");
        end
        host_u.sync(1'b0, 1'b0);
        repeat (30) @(posedge mclk);
        cmp(25'h1, 25'(sclk_oe), "drive");
        host_u.sync(1'b0, 1'b1);
        repeat (8) @(posedge mclk);
        cmp(25'h0, 25'({sclk_oe, rx_valid}), "abort");
        $display("test self done");
    endtask
    task automatic t_ext();
        logic [23:0] got;
        logic [24:0] d;
        mode <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            register_select <= s[0];
            repeat (10) @(posedge mclk);
            host_u.xfer(1'b0, 24'h5A0FC3 ^ 24'(s), s ? 5 : 24, got);
            get_rx(d);
            cmp({s[0], 24'h5A0FC3 ^ 24'(s)}, d, "rx");
            host_u.xfer(1'b1, 24'h0, s ? 7 : 24, got);
            cmp(25'(s ? DATA_W : CTRL_W), 25'(got), "ext read");
        end
        $display("test ext done");
    endtask
    // Fill the queue and output stage with the reader stalled, then one refused frame
    task automatic t_fifo();
        logic [23:0] got;
        logic [24:0] d;
        rx_ready <= 1'b0;
        for (int k = 0; k < 34; k++) begin
            host_u.xfer(1'b0, 24'(k), 24, got);
        end
        @(posedge mclk);
        for (int k = 0; k < 33; k++) begin
            get_rx(d);
            cmp({1'b1, 24'(k)}, d, "fifo");
        end
        repeat (100) @(negedge mclk);
        cmp(25'h0, 25'(rx_valid), "refused");
        cmp(25'h0, 25'(ovf_seen), "overflow");
        $display("test fifo done");
    endtask
    task automatic t_filter();
        @(posedge mclk);
        filter_sync <= 1'b1;
        repeat (7) @(posedge mclk);
        cmp(25'h1, 25'(filter_reset), "filter on");
        filter_sync <= 1'b0;
        repeat (7) @(posedge mclk);
        cmp(25'h0, 25'(filter_reset), "filter off");
        $display("test filter done");
    endtask
    // Master clock never stops during the run
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        mode = 1'b0;
        register_select = 1'b0;
        filter_sync = 1'b0;
        rx_ready = 1'b0;
        err_total = 0;
        checks = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        cmp(25'h10, 25'({sclk_o, sclk_oe, sdata_oe, rx_valid, filter_reset}), "idle");
        $display("test reset done");
        t_self();
        t_ext();
        t_fifo();
        t_filter();
        conclude();
    end
endmodule
